// [include/bfs_map.vh]
// Contract
// - initiate accepted only above supervision current
// - seal-in held only above supervision current
// - three-pole initiate starts three-pole scheme
// - neutral thresholds used only in three-pole
// - early path runs only when enabled
// - main path runs only when enabled
// - slow path runs only when enabled
// - delays tolerate one-cycle magnitude decay lag
// - early aux contact supervises early path
// - normal aux contact supervises slow path
// - out-of-service input accepted
// - high thresholds compare phase and neutral
// - low thresholds after delay from hiset
// - zone trip held for dropout period
// - cancel-reclose asserted on breaker failure
// - single-pole: separate per-phase initiates
// - single-pole: per-pole initiate, seal, timers
// - one common threshold set for poles
// - single-pole: separate re-trip per pole
// - any pole failure asserts zone trip
// - one phase threshold for initiate, seal-in
// - hiset enabled on timer one/two timeout
// - early output needs contact closed, current
// - slow path: no current, contact, test
// - re-trip registered one cycle after accepted initiate
`ifndef BFS_MAP_VH
`define BFS_MAP_VH

`define BFS_OFF_CTRL     12'h000
`define BFS_OFF_SUPV     12'h004
`define BFS_OFF_HISET    12'h008
`define BFS_OFF_LOSET    12'h00c
`define BFS_OFF_DLY12    12'h010
`define BFS_OFF_DLY3L    12'h014
`define BFS_OFF_HOLD     12'h018
`define BFS_OFF_STATUS   12'h01c

`define BFS_CTRL_SP      0
`define BFS_CTRL_INIGATE 1
`define BFS_CTRL_SEALEN  2
`define BFS_CTRL_EARLY   3
`define BFS_CTRL_MAIN    4
`define BFS_CTRL_SLOW    5
`define BFS_CTRL_RST     6'h38

`define BFS_THR_RST      32'h0419_0419
`define BFS_DLY_RST      32'h0000_0000

`define BFS_CLK_NS       200
`define BFS_CLK_PERIOD   5
`define BFS_TICK_US      1000
`define BFS_TICK_CYCLES  ((`BFS_TICK_US * 1000) / `BFS_CLK_PERIOD)

`endif

// [design/bfs_top.v]
`include "bfs_map.vh"

module bfs_top #(
  parameter [17:0] TICK_CYCLES = `BFS_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        three_pole_start_input,
  input  wire        pole_a_start_input,
  input  wire        pole_b_start_input,
  input  wire        pole_c_start_input,
  input  wire        early_aux_contact_input,
  input  wire        pole_b_early_contact,
  input  wire        pole_c_early_contact,
  input  wire        normal_aux_contact_input,
  input  wire        pole_b_normal_contact,
  input  wire        pole_c_normal_contact,
  input  wire        out_of_service_input,
  input  wire [15:0] cur_a,
  input  wire [15:0] cur_b,
  input  wire [15:0] cur_c,
  input  wire [15:0] cur_n,
  output reg  [2:0]  retrip_q,
  output reg         zone_trip_output,
  output reg         cancel_reclose_q
);

  // settings
  reg  [5:0]  ctrl_q;
  reg  [31:0] supv_q;
  reg  [31:0] hiset_q;
  reg  [31:0] loset_q;
  reg  [31:0] dly12_q;
  reg  [31:0] dly3l_q;
  reg  [15:0] hold_q;

  wire        single_pole_mode = ctrl_q[`BFS_CTRL_SP];
  wire        initiate_current_gate_enable = ctrl_q[`BFS_CTRL_INIGATE];
  wire        sealin_current_gate_enable = ctrl_q[`BFS_CTRL_SEALEN];
  wire        early_path_enable = ctrl_q[`BFS_CTRL_EARLY];
  wire        main_path_enable = ctrl_q[`BFS_CTRL_MAIN];
  wire        slow_path_enable = ctrl_q[`BFS_CTRL_SLOW];
  wire [15:0] phase_supervision_threshold = supv_q[15:0];
  wire [15:0] neutral_supervision_threshold = supv_q[31:16];
  wire [15:0] phase_high_threshold = hiset_q[15:0];
  wire [15:0] neutral_high_threshold = hiset_q[31:16];
  wire [15:0] phase_low_threshold = loset_q[15:0];
  wire [15:0] neutral_low_threshold = loset_q[31:16];
  wire [15:0] early_path_delay = dly12_q[15:0];
  wire [15:0] main_path_delay = dly12_q[31:16];
  wire [15:0] slow_path_delay = dly3l_q[15:0];
  wire [15:0] low_threshold_delay = dly3l_q[31:16];
  wire [15:0] trip_hold_period = hold_q;

  // two-flop synchroniser for discrete inputs
  reg  [10:0] sync1_q;
  reg  [10:0] sync2_q;
  wire [10:0] raw_in = {out_of_service_input,
                        pole_c_normal_contact, pole_b_normal_contact,
                        normal_aux_contact_input,
                        pole_c_early_contact, pole_b_early_contact,
                        early_aux_contact_input,
                        pole_c_start_input, pole_b_start_input,
                        pole_a_start_input, three_pole_start_input};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire       three_pole_s = sync2_q[0];
  wire [2:0] pole_start_s = sync2_q[3:1];
  wire [2:0] early_ct_s = sync2_q[6:4];
  wire [2:0] normal_ct_s = sync2_q[9:7];
  wire       oos_s = sync2_q[10];

  // periodic tick
  reg  [17:0] tick_cnt_q;
  reg         tick_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES - 18'h00001) begin
      tick_cnt_q <= 18'h00000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 18'h00001;
      tick_q <= 1'b0;
    end
  end

  // common detectors, one threshold set for all poles
  wire [15:0] cur_ph [0:2];
  assign cur_ph[0] = cur_a;
  assign cur_ph[1] = cur_b;
  assign cur_ph[2] = cur_c;

  wire [2:0] ph_sup;
  wire [2:0] ph_hi;
  wire [2:0] ph_lo;
  wire n_sup = cur_n > neutral_supervision_threshold;
  wire n_hi = cur_n > neutral_high_threshold;
  wire n_lo = cur_n > neutral_low_threshold;

  wire [2:0] active;
  wire [2:0] sealed;
  wire [2:0] hiset_on;
  wire [2:0] loset_on;
  wire [2:0] early_op;
  wire [2:0] main_op;
  wire [2:0] slow_op;

  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_pole
      reg  [15:0] elapsed_q;
      reg  [15:0] lo_elapsed_q;
      reg         sealed_q;
      reg         hiset_q2;
      wire        sup_p;
      wire        hi_p;
      wire        lo_p;
      wire        init_p;
      wire        acc_p;
      wire        t1_done;
      wire        t2_done;
      wire        t3_done;
      wire        cur_ok;
      wire        lo_on;

      assign ph_sup[p] = cur_ph[p] > phase_supervision_threshold;
      assign ph_hi[p] = cur_ph[p] > phase_high_threshold;
      assign ph_lo[p] = cur_ph[p] > phase_low_threshold;

      // three-pole: any phase or neutral; single-pole: own phase only
      assign sup_p = single_pole_mode ? ph_sup[p] :
                     ((|ph_sup) | n_sup);
      assign hi_p = single_pole_mode ? ph_hi[p] :
                    ((|ph_hi) | n_hi);
      assign lo_p = single_pole_mode ? ph_lo[p] :
                    ((|ph_lo) | n_lo);

      if (p == 0) begin : g_init0
        assign init_p = single_pole_mode ?
                        (pole_start_s[0] | three_pole_s) :
                        three_pole_s;
      end else begin : g_initn
        assign init_p = single_pole_mode &
                        (pole_start_s[p] | three_pole_s);
      end

      assign acc_p = init_p &
                     (~initiate_current_gate_enable | sup_p);
      assign active[p] = acc_p | sealed_q;
      assign sealed[p] = sealed_q;

      // elapsed time since accepted initiate, in ticks
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sealed_q <= 1'b0;
          elapsed_q <= 16'h0000;
        end else begin
          sealed_q <= sealin_current_gate_enable &
                      active[p] & sup_p;
          if (!active[p])
            elapsed_q <= 16'h0000;
          else if (tick_q && elapsed_q != 16'hffff)
            elapsed_q <= elapsed_q + 16'h0001;
        end
      end

      assign t1_done = early_path_enable & active[p] &
                       (elapsed_q >= early_path_delay);
      assign t2_done = main_path_enable & active[p] &
                       (elapsed_q >= main_path_delay);
      assign t3_done = slow_path_enable & active[p] &
                       (elapsed_q >= slow_path_delay);

      // hiset armed at timer one/two timeout, loset after delay
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hiset_q2 <= 1'b0;
          lo_elapsed_q <= 16'h0000;
        end else begin
          hiset_q2 <= t1_done | t2_done;
          if (!(t1_done | t2_done))
            lo_elapsed_q <= 16'h0000;
          else if (tick_q && lo_elapsed_q != 16'hffff)
            lo_elapsed_q <= lo_elapsed_q + 16'h0001;
        end
      end

      assign lo_on = hiset_q2 &
                     (lo_elapsed_q >= low_threshold_delay);
      assign hiset_on[p] = hiset_q2;
      assign loset_on[p] = lo_on;

      // current checked only after the path delay expires, so the
      // magnitude decay lag is absorbed in the delay setting
      assign cur_ok = hiset_q2 & (hi_p | (lo_on & lo_p));

      assign early_op[p] = t1_done & early_ct_s[p] & cur_ok;
      assign main_op[p] = t2_done & cur_ok;
      assign slow_op[p] = t3_done & normal_ct_s[p] & ~oos_s;
    end
  endgenerate

  wire fail_any = |(early_op | main_op | slow_op);

  // trip seal-in dropout
  reg [15:0] hold_cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 16'h0000;
      zone_trip_output <= 1'b0;
      cancel_reclose_q <= 1'b0;
      retrip_q <= 3'h0;
    end else begin
      if (fail_any)
        hold_cnt_q <= trip_hold_period;
      else if (tick_q && hold_cnt_q != 16'h0000)
        hold_cnt_q <= hold_cnt_q - 16'h0001;
      zone_trip_output <= fail_any |
                          (hold_cnt_q != 16'h0000);
      cancel_reclose_q <= fail_any |
                          (hold_cnt_q != 16'h0000);
      retrip_q <= single_pole_mode ? active :
                  {3{active[0]}};
    end
  end

  // apb slave, one wait-free access cycle
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  always @* begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `BFS_OFF_CTRL:   rd_mux = {26'h0000000, ctrl_q};
      `BFS_OFF_SUPV:   rd_mux = supv_q;
      `BFS_OFF_HISET:  rd_mux = hiset_q;
      `BFS_OFF_LOSET:  rd_mux = loset_q;
      `BFS_OFF_DLY12:  rd_mux = dly12_q;
      `BFS_OFF_DLY3L:  rd_mux = dly3l_q;
      `BFS_OFF_HOLD:   rd_mux = {16'h0000, hold_q};
      `BFS_OFF_STATUS: rd_mux = {6'h00, cancel_reclose_q, zone_trip_output,
                                 retrip_q, slow_op, main_op, early_op,
                                 loset_on, hiset_on, sealed, active};
      default:         addr_ok = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addr_ok;
      prdata <= (setup & ~pwrite & addr_ok) ? rd_mux : 32'h0000_0000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `BFS_CTRL_RST;
      supv_q <= `BFS_THR_RST;
      hiset_q <= `BFS_THR_RST;
      loset_q <= `BFS_THR_RST;
      dly12_q <= `BFS_DLY_RST;
      dly3l_q <= `BFS_DLY_RST;
      hold_q <= 16'h0000;
    end else if (wr_en && !pslverr) begin
      case (paddr)
        `BFS_OFF_CTRL:  ctrl_q <= pwdata[5:0];
        `BFS_OFF_SUPV:  supv_q <= pwdata;
        `BFS_OFF_HISET: hiset_q <= pwdata;
        `BFS_OFF_LOSET: loset_q <= pwdata;
        `BFS_OFF_DLY12: dly12_q <= pwdata;
        `BFS_OFF_DLY3L: dly3l_q <= pwdata;
        `BFS_OFF_HOLD:  hold_q <= pwdata[15:0];
        default:        hold_q <= hold_q;
      endcase
    end
  end

endmodule

// [dv/bfs_chk.sv]
module bfs_chk (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        three_pole_start_input,
  input logic        pole_a_start_input,
  input logic [2:0]  retrip_q,
  input logic        zone_trip_output,
  input logic        cancel_reclose_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on refused access");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_cancel_follows_zone: assert property (
    cancel_reclose_q == zone_trip_output)
    else $error("cancel reclose differs from zone trip");
  a_retrip_has_cause: assert property ($rose(retrip_q[0]) |->
    $past(three_pole_start_input || pole_a_start_input, 3))
    else $error("retrip without initiate");
  a_zone_after_retrip: assert property (
    $rose(zone_trip_output) |-> |retrip_q)
    else $error("zone trip without active pole");
  cover property ($rose(zone_trip_output));
  cover property (pslverr);
  cover property ($rose(retrip_q[1]));
endmodule

bind bfs_top bfs_chk chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .three_pole_start_input(three_pole_start_input),
  .pole_a_start_input(pole_a_start_input), .retrip_q(retrip_q),
  .zone_trip_output(zone_trip_output),
  .cancel_reclose_q(cancel_reclose_q)
);

// [dv/bfs_partner.sv]
module bfs_partner #(
  parameter int OPEN_DLY = 20,
  parameter int LAG      = 5
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic [2:0]  retrip,
  input  logic [2:0]  flt,
  input  logic        tp,
  input  logic        stk,
  input  logic [15:0] lv,
  input  logic [15:0] ln,
  output logic        start_tp,
  output logic [2:0]  start_p,
  output logic [2:0]  early_c,
  output logic [2:0]  normal_c,
  output logic [15:0] cur_a,
  output logic [15:0] cur_b,
  output logic [15:0] cur_c,
  output logic [15:0] cur_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt [3];
  logic [2:0] live;
  // breaker opens after a re-trip unless commanded stuck
  always @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 3; i++) begin
      if (!presetn || !flt[i])
        cnt[i] <= 8'h0;
      else if (retrip[i] && !stk && cnt[i] < 8'hff)
        cnt[i] <= cnt[i] + 8'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      live[i] = flt[i] && (cnt[i] < OPEN_DLY + LAG);
      early_c[i] = cnt[i] < OPEN_DLY;
      normal_c[i] = cnt[i] < OPEN_DLY + 2;
    end
  end
  assign start_tp = tp && live[0];
  assign start_p  = tp ? 3'h0 : live;
  assign cur_a    = live[0] ? lv : 16'h0;
  assign cur_b    = live[1] ? lv : 16'h0;
  assign cur_c    = live[2] ? lv : 16'h0;
  assign cur_n    = |live ? ln : 16'h0;
endmodule

// [dv/bfs_tb_top.sv]
module bfs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0]  ctrl;
    logic [2:0]  flt;
    logic        stk;
    logic        oos;
    logic [15:0] lv;
    logic [15:0] ln;
    logic [2:0]  rt;
    logic        z;
  } bfs_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        zone, cancel, tp, stk, oos, se, start_tp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_v;
  logic [2:0]  retrip, flt, start_p, early_c, normal_c;
  logic [15:0] lv, ln, cur_a, cur_b, cur_c, cur_n;
  int          failures, checked, cyc;
  bfs_row_t    r;
  bfs_row_t    rows [10];
  bfs_top #(.TICK_CYCLES(18'd20)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .three_pole_start_input(start_tp), .pole_a_start_input(start_p[0]),
    .pole_b_start_input(start_p[1]), .pole_c_start_input(start_p[2]),
    .early_aux_contact_input(early_c[0]),
    .pole_b_early_contact(early_c[1]), .pole_c_early_contact(early_c[2]),
    .normal_aux_contact_input(normal_c[0]),
    .pole_b_normal_contact(normal_c[1]),
    .pole_c_normal_contact(normal_c[2]), .out_of_service_input(oos),
    .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .cur_n(cur_n),
    .retrip_q(retrip), .zone_trip_output(zone), .cancel_reclose_q(cancel)
  );
  bfs_partner partner (
    .pclk(pclk), .presetn(presetn), .retrip(retrip), .flt(flt), .tp(tp),
    .stk(stk), .lv(lv), .ln(ln), .start_tp(start_tp), .start_p(start_p),
    .early_c(early_c), .normal_c(normal_c), .cur_a(cur_a), .cur_b(cur_b),
    .cur_c(cur_c), .cur_n(cur_n)
  );
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic ok, input string m);
    checked++;
    if (!ok) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {flt, tp, stk, oos, lv, ln, failures, checked, cyc} = '0;
    rows = '{{6'h10, 3'd1, 2'b10, 16'h800, 16'h0, 4'hf},
             {6'h10, 3'd1, 2'b00, 16'h800, 16'h0, 4'he},
             {6'h00, 3'd1, 2'b10, 16'h800, 16'h0, 4'he},
             {6'h12, 3'd1, 2'b10, 16'h080, 16'h0, 4'h0},
             {6'h08, 3'd1, 2'b10, 16'h800, 16'h0, 4'hf},
             {6'h20, 3'd1, 2'b10, 16'h000, 16'h0, 4'hf},
             {6'h21, 3'd2, 2'b10, 16'h000, 16'h0, 4'h5},
             {6'h13, 3'd1, 2'b10, 16'h0, 16'h800, 4'h0},
             {6'h12, 3'd1, 2'b10, 16'h0, 16'h800, 4'hf},
             {6'h20, 3'd1, 2'b11, 16'h000, 16'h0, 4'he}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      exp_v = (i == 0) ? 32'h38 : (i < 4) ? 32'h0419_0419 : 32'h0;
      chk(rd === exp_v && se === (i == 8), "reset value");
    end
    apb(1'b1, 12'h004, 32'h0100_0100);
    apb(1'b1, 12'h008, 32'h0100_0100);
    apb(1'b1, 12'h00c, 32'h0080_0080);
    apb(1'b1, 12'h010, 32'h0004_0002);
    apb(1'b1, 12'h014, 32'h0002_0008);
    apb(1'b1, 12'h018, 32'h0000_0004);
    apb(1'b1, 12'h020, 32'h0000_0007);
    chk(se === 1'b1, "unmapped write accepted");
    apb(1'b0, 12'h018, 32'h0);
    chk(rd === 32'h4 && se === 1'b0, "hold readback");
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      apb(1'b1, 12'h000, {26'h0, r.ctrl});
      @(posedge pclk);
      {flt, stk, oos, lv, ln} <= {r.flt, r.stk, r.oos, r.lv, r.ln};
      tp <= !r.ctrl[0];
      repeat (10) @(posedge pclk);
      chk(retrip === r.rt, "retrip");
      repeat (240) @(posedge pclk);
      chk(zone === r.z, "zone trip");
      flt <= 3'h0;
      repeat (40) @(posedge pclk);
      chk(zone === r.z, "trip hold");
      repeat (200) @(posedge pclk);
      chk(zone === 1'b0 && retrip === 3'h0, "not idle");
    end
    {flt, tp, stk, oos, lv} <= {3'd1, 2'b11, 1'b0, 16'h800};
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk(zone === 1'b0 && retrip === 3'h0, "outputs in reset");
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(zone === 1'b1 && cancel === 1'b1, "defaults trip");
    wrap_up;
  end
endmodule
